/* File: rtl/lcs_input_select.sv */
// Operation
// [RULE1] Data-2 field bits 6:4 picks index code+4
// [RULE2] Data-1 field bits 2:0 picks index code
// [RULE3] Bits 7 and 3 read zero, ignore writes
// [RULE4] Second register: data-4 high, data-3 low
// [RULE5] Fields read/write, unreset, kept through resets
// [RULE6] Data-3 field picks index code+8
// [RULE7] Data-4 codes 100-111 pick 0-3, else 12-15
// [RULE8] Data-1 codes 010,001,000 pick 2,1,0
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module lcs_input_select
	import lcs_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [BUS_W-1:0]  cell_input_bus,
	output logic                   cell_data_line_1,
	output logic                   cell_data_line_2,
	output logic                   cell_data_line_3,
	output logic                   cell_data_line_4
);

	// ***********************************************************
	// Helpers
	// ***********************************************************
	function automatic logic [IDX_W-1:0] src_index(
		input logic [CODE_W-1:0] code,
		input logic [IDX_W-1:0]  base
	);
		logic [IDX_W-1:0] wide;
		wide = {1'b0, code};
		return IDX_W'(wide + base);
	endfunction

	function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
		return (addr == LOW_PAIR_OFFSET) || (addr == HIGH_PAIR_OFFSET);
	endfunction

	// ***********************************************************
	// Select fields
	// ***********************************************************
	logic [CODE_W-1:0] data1_source_code_reg;
	logic [CODE_W-1:0] data2_source_code_reg;
	logic [CODE_W-1:0] data3_source_code_reg;
	logic [CODE_W-1:0] data4_source_code_reg;
	logic [CODE_W-1:0] data1_source_code_next;
	logic [CODE_W-1:0] data2_source_code_next;
	logic [CODE_W-1:0] data3_source_code_next;
	logic [CODE_W-1:0] data4_source_code_next;

	// ***********************************************************
	// Write channel state
	// ***********************************************************
	logic              aw_got_reg;
	logic              aw_got_next;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [ADDR_W-1:0] awaddr_next;
	logic              w_got_reg;
	logic              w_got_next;
	logic [7:0]        wbyte_reg;
	logic [7:0]        wbyte_next;
	logic              wen_reg;
	logic              wen_next;
	logic              bvalid_reg;
	logic              bvalid_next;
	logic [1:0]        bresp_reg;
	logic [1:0]        bresp_next;
	logic              do_write;

	assign s_axi_awready = !aw_got_reg && !bvalid_reg;
	assign s_axi_wready  = !w_got_reg && !bvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign do_write      = aw_got_reg && w_got_reg && !bvalid_reg;

	always_comb begin
		aw_got_next = aw_got_reg;
		awaddr_next = awaddr_reg;
		w_got_next  = w_got_reg;
		wbyte_next  = wbyte_reg;
		wen_next    = wen_reg;
		bvalid_next = bvalid_reg;
		bresp_next  = bresp_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_got_next = 1'b1;
			awaddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_got_next = 1'b1;
			wbyte_next = s_axi_wdata[7:0];
			wen_next   = s_axi_wstrb[0];
		end
		if (do_write) begin
			aw_got_next = 1'b0;
			w_got_next  = 1'b0;
			bvalid_next = 1'b1;
			bresp_next  = is_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_got_reg <= 1'b0;
			awaddr_reg <= '0;
			w_got_reg  <= 1'b0;
			wbyte_reg  <= '0;
			wen_reg    <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end else begin
			aw_got_reg <= aw_got_next;
			awaddr_reg <= awaddr_next;
			w_got_reg  <= w_got_next;
			wbyte_reg  <= wbyte_next;
			wen_reg    <= wen_next;
			bvalid_reg <= bvalid_next;
			bresp_reg  <= bresp_next;
		end
	end

	// ***********************************************************
	// Field update, bits 7 and 3 dropped
	// ***********************************************************
	always_comb begin
		data1_source_code_next = data1_source_code_reg;
		data2_source_code_next = data2_source_code_reg;
		data3_source_code_next = data3_source_code_reg;
		data4_source_code_next = data4_source_code_reg;
		if (do_write && wen_reg) begin
			if (awaddr_reg == LOW_PAIR_OFFSET) begin
				data1_source_code_next =
					wbyte_reg[LOW_FIELD_LSB +: CODE_W]; // see [RULE2]
				data2_source_code_next =
					wbyte_reg[HIGH_FIELD_LSB +: CODE_W]; // see [RULE1]
			end else if (awaddr_reg == HIGH_PAIR_OFFSET) begin
				data3_source_code_next =
					wbyte_reg[LOW_FIELD_LSB +: CODE_W]; // see [RULE4]
				data4_source_code_next =
					wbyte_reg[HIGH_FIELD_LSB +: CODE_W]; // see [RULE4]
			end
		end
	end

	// No reset: fields survive every reset of this block, see [RULE5]
	always_ff @(posedge clk) begin
		data1_source_code_reg <= data1_source_code_next;
		data2_source_code_reg <= data2_source_code_next;
		data3_source_code_reg <= data3_source_code_next;
		data4_source_code_reg <= data4_source_code_next;
	end

	// ***********************************************************
	// Read channel
	// ***********************************************************
	logic              rvalid_reg;
	logic              rvalid_next;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic [1:0]        rresp_reg;
	logic [1:0]        rresp_next;
	logic [7:0]        read_byte;

	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	always_comb begin
		read_byte = '0;
		if (s_axi_araddr == LOW_PAIR_OFFSET) begin
			read_byte[LOW_FIELD_LSB +: CODE_W]  = data1_source_code_reg;
			read_byte[HIGH_FIELD_LSB +: CODE_W] = data2_source_code_reg;
		end else if (s_axi_araddr == HIGH_PAIR_OFFSET) begin
			read_byte[LOW_FIELD_LSB +: CODE_W]  = data3_source_code_reg;
			read_byte[HIGH_FIELD_LSB +: CODE_W] = data4_source_code_reg;
		end
		rvalid_next = rvalid_reg;
		rdata_next  = rdata_reg;
		rresp_next  = rresp_reg;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rdata_next  = {24'h00_0000, read_byte}; // see [RULE3]
			rresp_next  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= RESP_OKAY;
		end else begin
			rvalid_reg <= rvalid_next;
			rdata_reg  <= rdata_next;
			rresp_reg  <= rresp_next;
		end
	end

	// ***********************************************************
	// Input multiplexers
	// ***********************************************************
	always_comb begin
		cell_data_line_1 = cell_input_bus[src_index(
			data1_source_code_reg, LINE1_BASE)]; // see [RULE2] see [RULE8]
		cell_data_line_2 = cell_input_bus[src_index(
			data2_source_code_reg, LINE2_BASE)]; // see [RULE1]
		cell_data_line_3 = cell_input_bus[src_index(
			data3_source_code_reg, LINE3_BASE)]; // see [RULE6]
		cell_data_line_4 = cell_input_bus[src_index(
			data4_source_code_reg, LINE4_BASE)]; // see [RULE7]
	end

	// ***********************************************************
	// Assertions
	// ***********************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_write_low;
		do_write && wen_reg && awaddr_reg == LOW_PAIR_OFFSET;
	endsequence

	sequence s_write_high;
		do_write && wen_reg && awaddr_reg == HIGH_PAIR_OFFSET;
	endsequence

	property p_line2;
		s_write_low |=> cell_data_line_2 ==
			cell_input_bus[{1'b0, $past(wbyte_reg[6:4])} + 4'h4];
	endproperty
	a_line2: assert property (p_line2) // see [RULE1]
		else $error("data line 2 source wrong");

	property p_line1;
		s_write_low ##1 data1_source_code_reg >= 3'h3 |->
			cell_data_line_1 ==
			cell_input_bus[{1'b0, data1_source_code_reg}];
	endproperty
	a_line1: assert property (p_line1) // see [RULE2]
		else $error("data line 1 source wrong");

	property p_gap_zero;
		$rose(rvalid_reg) |-> rdata_reg[7] == 1'b0 &&
			rdata_reg[3] == 1'b0 && rdata_reg[31:8] == '0;
	endproperty
	a_gap_zero: assert property (p_gap_zero) // see [RULE3]
		else $error("unimplemented bit read nonzero");

	property p_high_layout;
		s_write_high |=> data3_source_code_reg == $past(wbyte_reg[2:0])
			&& data4_source_code_reg == $past(wbyte_reg[6:4]);
	endproperty
	a_high_layout: assert property (p_high_layout) // see [RULE4]
		else $error("second register layout wrong");

	property p_readback;
		s_write_low ##1 (s_axi_arvalid && s_axi_arready &&
			s_axi_araddr == LOW_PAIR_OFFSET && !do_write) |=>
			rdata_reg[7:0] == ($past(wbyte_reg, 2) & 8'h77);
	endproperty
	a_readback: assert property (p_readback) // see [RULE5]
		else $error("select field readback wrong");

	property p_line3;
		s_write_high |=> cell_data_line_3 ==
			cell_input_bus[{1'b1, $past(wbyte_reg[2:0])}];
	endproperty
	a_line3: assert property (p_line3) // see [RULE6]
		else $error("data line 3 source wrong");

	property p_line4;
		s_write_high ##1 data4_source_code_reg[2] |->
			cell_data_line_4 ==
			cell_input_bus[{2'b00, data4_source_code_reg[1:0]}];
	endproperty
	a_line4: assert property (p_line4) // see [RULE7]
		else $error("data line 4 source wrong");

	property p_line1_low;
		s_write_low ##1 data1_source_code_reg < 3'h3 |->
			cell_data_line_1 ==
			cell_input_bus[{2'b00, data1_source_code_reg[1:0]}];
	endproperty
	a_line1_low: assert property (p_line1_low) // see [RULE8]
		else $error("data line 1 low code source wrong");

	property p_bresp_follows;
		do_write |=> s_axi_bvalid;
	endproperty
	a_bresp_follows: assert property (p_bresp_follows)
		else $error("write response missing");
endmodule

/* File: rtl/lcs_pkg.sv */
package lcs_pkg;
	localparam int unsigned ADDR_W       = 4;
	localparam int unsigned DATA_W       = 32;
	localparam int unsigned BUS_W        = 16;
	localparam int unsigned CODE_W       = 3;
	localparam int unsigned IDX_W        = 4;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] LOW_PAIR_OFFSET  = 4'h0;
	localparam logic [ADDR_W-1:0] HIGH_PAIR_OFFSET = 4'h4;

	// Field positions inside each select register
	localparam int unsigned LOW_FIELD_LSB  = 0;
	localparam int unsigned HIGH_FIELD_LSB = 4;
	localparam int unsigned GAP_LOW_BIT    = 3;
	localparam int unsigned GAP_HIGH_BIT   = 7;

	// Input bus index added to each field code, modulo 16
	localparam logic [IDX_W-1:0] LINE1_BASE = 4'h0;
	localparam logic [IDX_W-1:0] LINE2_BASE = 4'h4;
	localparam logic [IDX_W-1:0] LINE3_BASE = 4'h8;
	localparam logic [IDX_W-1:0] LINE4_BASE = 4'hc;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: verif/lcs_source_model.sv */
`timescale 1ns/1ps
// ********************
// Source signals
// ********************
module lcs_source_model
	import lcs_pkg::*;
(
	input  wire logic             clk,
	input  wire logic [BUS_W-1:0] next_sources,
	output logic      [BUS_W-1:0] cell_input_bus
);
	// Sources change only just after a rising edge
	always @(posedge clk) begin
		cell_input_bus <= next_sources;
	end
endmodule

/* File: verif/test_logic_cell_input_select.sv */
`timescale 1ns/1ps
module test_logic_cell_input_select
	import lcs_pkg::*;
;
	logic              clk;
	logic              rst_n;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic              awvalid, wvalid, bready, arvalid, rready;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [DATA_W-1:0] wdata, rdata, d;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp, r, rr;
	logic [BUS_W-1:0]  pat, bus;
	logic              l1, l2, l3, l4;
	logic [2:0]        c;
	int                fails, num_checks;

	lcs_input_select u_lcs_input_select (
		.clk(clk), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .cell_input_bus(bus),
		.cell_data_line_1(l1), .cell_data_line_2(l2),
		.cell_data_line_3(l3), .cell_data_line_4(l4)
	);
	lcs_source_model u_lcs_source_model (
		.clk(clk), .next_sources(pat), .cell_input_bus(bus)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic print_verdict();
		if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] v,
		input logic [3:0] s, output logic [1:0] rs);
		@(posedge clk);
		awaddr <= a; wdata <= v; wstrb <= s;
		awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] v,
		output logic [1:0] rs);
		@(posedge clk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		v = rdata; rs = rresp;
		rready <= 1'b0;
	endtask

	function automatic logic pick(input logic [15:0] b,
		input logic [2:0] k, input logic [3:0] base);
		logic [3:0] i;
		i = {1'b0, k} + base;
		return b[i];
	endfunction

	// Codes per line are c, c+1, c+2, c+3
	task automatic lines(input logic [2:0] k);
		logic [15:0] v;
		v = 16'($urandom);
		for (int j = 0; j < 2; j++) begin
			@(posedge clk);
			pat <= j ? ~v : v;
			repeat (2) @(posedge clk);
			#1;
			chk("line1", pick(pat, k, LINE1_BASE), l1);
			chk("line2", pick(pat, k + 3'h1, LINE2_BASE), l2);
			chk("line3", pick(pat, k + 3'h2, LINE3_BASE), l3);
			chk("line4", pick(pat, k + 3'h3, LINE4_BASE), l4);
		end
	endtask

	task automatic regs(input logic [2:0] k);
		rd(LOW_PAIR_OFFSET, d, r);
		chk("low", {25'h0, k + 3'h1, 1'b0, k}, d);
		rd(HIGH_PAIR_OFFSET, d, r);
		chk("high", {25'h0, k + 3'h3, 1'b0, k + 3'h2}, d);
	endtask

	initial begin
		fails = 0; num_checks = 0;
		rst_n = 1'b0; pat = '0; awaddr = '0; araddr = '0;
		awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
		arvalid = 1'b0; rready = 1'b0; wdata = '0; wstrb = '0;
		void'($urandom(32'hb933));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			c = 3'(k);
			d = $urandom;
			d[7:0] = {1'b1, c + 3'h1, 1'b1, c};
			wr(LOW_PAIR_OFFSET, d, 4'hf, r);
			chk("bresp", RESP_OKAY, r);
			d = $urandom;
			d[7:0] = {1'b1, c + 3'h3, 1'b1, c + 3'h2};
			wr(HIGH_PAIR_OFFSET, d, 4'hf, r);
			regs(c);
			lines(c);
		end
		wr(LOW_PAIR_OFFSET, 32'h0000_0000, 4'he, r);
		chk("bresp", RESP_OKAY, r);
		regs(c);
		wr(4'h8, 32'h0000_0000, 4'hf, r);
		chk("bresp", RESP_SLVERR, r);
		rd(4'h8, d, r);
		chk("rdata", 32'h0000_0000, d);
		chk("rresp", RESP_SLVERR, r);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		regs(c);
		lines(c);
		// Read taken in the cycle right after the field update
		fork
			wr(LOW_PAIR_OFFSET, 32'h0000_00d2, 4'hf, r);
			begin
				repeat (2) @(posedge clk);
				rd(LOW_PAIR_OFFSET, d, rr);
			end
		join
		chk("bresp", RESP_OKAY, r);
		chk("low_behind_write", 32'h0000_0052, d);
		chk("rresp", RESP_OKAY, rr);
		print_verdict();
	end

	initial begin
		#(25 * 5000);
		fails++;
		print_verdict();
	end
endmodule
